// File: rtl/pmt_core.sv
// program memory, fetch, table read and serial programming pins
`timescale 1ns/1ns
`default_nettype none
`include "pmt_defs.svh"
module pmt_core
  import pmt_pkg::*;
#(
  parameter int ADDR_W = 11,
  parameter logic [15:0] HIGH_MASK = 16'hffff,
  parameter bit EMULATION = 1'b0
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // core control
  input wire logic i_jump,
  input wire logic [ADDR_W-1:0] i_jump_addr,
  input wire logic i_tab_req,
  input wire logic i_tab_last,
  input wire logic [7:0] i_tblp,
  input wire logic [7:0] i_tbhp,
  input wire logic [7:0] i_tab_dst,
  // fetch and table results
  output logic [ADDR_W-1:0] o_pc,
  output logic [15:0] o_instr,
  output logic o_instr_valid,
  output logic o_dm_wr,
  output logic [7:0] o_dm_addr,
  output logic [7:0] o_dm_data,
  output logic [7:0] o_table_high_latch,
  output logic o_busy,
  // programming and debug pins
  input wire logic i_prog_mode,
  input wire logic i_prog_serial_clock,
  input wire logic i_prog_serial_data,
  output logic o_prog_serial_data,
  output logic o_prog_serial_data_oe,
  // data eeprom write port
  output logic o_ee_wr,
  output logic [7:0] o_ee_addr,
  output logic [7:0] o_ee_data,
  // debug frame out
  output logic o_dbg_valid,
  output logic [31:0] o_dbg_word,
  // port a sharing
  input wire logic i_port_a_bit_zero_out,
  input wire logic i_port_a_bit_zero_oe,
  output logic o_port_a_bit_zero_pad,
  output logic o_port_a_bit_zero_pad_oe,
  input wire logic i_port_a_bit_two_out,
  input wire logic i_port_a_bit_two_oe,
  output logic o_port_a_bit_two_pad,
  output logic o_port_a_bit_two_pad_oe
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [5:0] FRAME_LAST = 6'(`PMT_FRAME_BITS - 1);
  localparam logic [5:0] HALF_LAST = 6'(`PMT_FRAME_BITS / 2 - 1);
  localparam int PAGES = DEPTH / `PMT_PAGE_WORDS;

  // program memory array, no reset
  logic [15:0] pmem [DEPTH];
  // fetch sequencer and table capture
  pmt_state_type st_r, st_nxt;
  logic [ADDR_W-1:0] pc_r;
  logic [ADDR_W-1:0] pc_nxt;
  logic [ADDR_W-1:0] tab_addr_r;
  logic [7:0] dst_r;
  // pin synchronisers and edge history
  logic ck_s1_r, ck_s2_r, ck_s3_r;
  logic da_s1_r, da_s2_r;
  // serial frame shifter and read-back
  logic [31:0] sh_r;
  logic [5:0] cnt_r;
  logic [15:0] rd_sh_r;
  // shared pin requests and pad drive, one entry per pin
  logic [1:0] gp_out, gp_oe;
  wire [1:0] pad_q, pad_oe_q;
  // sequencer state decode
  wire st_fetch = (st_r == PMT_FETCH);
  wire st_table = (st_r == PMT_TABLE);
  wire tab_take = st_fetch & i_tab_req;
  wire jump_take = st_fetch & i_jump;
  wire fetch_go = ~jump_take & ~st_table;
  wire pc_hold = st_table;
  // table address: page from the high pointer or the top page
  wire [7:0] last_page = 8'(PAGES - 1);
  wire [7:0] sel_page = i_tab_last ? last_page : i_tbhp;
  wire [15:0] tab_full = {sel_page, i_tblp};
  wire [ADDR_W-1:0] tab_addr = tab_full[ADDR_W-1:0];
  // words read from the array
  wire [15:0] tab_raw = pmem[tab_addr_r];
  wire [15:0] tab_word = tab_raw & HIGH_MASK;
  wire [15:0] fetch_word = pmem[pc_r];
  // fetch address: jump target or the next word
  assign pc_nxt = jump_take ? i_jump_addr : pc_r + 1'b1;
  // link clock edges from the synchronised pin
  wire ck_rise = ck_s2_r & ~ck_s3_r;
  wire ck_fall = ~ck_s2_r & ck_s3_r;
  wire pins_taken = i_prog_mode | EMULATION;
  wire bit_take = pins_taken & ck_rise;
  wire frame_done = bit_take & (cnt_r == FRAME_LAST);
  wire half_done = bit_take & (cnt_r == HALF_LAST);
  wire [31:0] frame = {sh_r[30:0], da_s2_r};
  // frame fields: read flag, eeprom flag, address, data
  wire frm_is_rd = frame[`PMT_FRM_RD];
  wire frm_is_ee = frame[`PMT_FRM_EE];
  wire [ADDR_W-1:0] frm_addr = frame[`PMT_FRM_AD_LO +: ADDR_W];
  wire [7:0] frm_ee_addr = frame[`PMT_FRM_AD_LO +: 8];
  wire frm_prog = frame_done & i_prog_mode & ~frm_is_rd;
  wire frm_wr_pm = frm_prog & ~frm_is_ee;
  wire frm_wr_ee = frm_prog & frm_is_ee;
  wire frm_dbg = frame_done & EMULATION & ~i_prog_mode;
  // read request: first frame bit seen at the half-way rise, address below it
  wire frm_rd = half_done & i_prog_mode & frame[15];
  wire [ADDR_W-1:0] rd_addr = frame[ADDR_W-1:0];
  wire rd_shift = ck_fall & o_prog_serial_data_oe;
  wire rd_end = rd_shift & (cnt_r == 6'h00);
  // shared pin requests gathered per pin
  assign gp_out = {i_port_a_bit_two_out, i_port_a_bit_zero_out};
  assign gp_oe = {i_port_a_bit_two_oe, i_port_a_bit_zero_oe};
  // next state of the fetch sequencer
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      PMT_FETCH: if (i_tab_req) st_nxt = PMT_TABLE;
      PMT_TABLE: st_nxt = PMT_RESUME;
      PMT_RESUME: st_nxt = PMT_FETCH;
      default: st_nxt = PMT_FETCH;
    endcase
  end
  // sequencer state
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= PMT_FETCH;
    end else begin
      st_r <= st_nxt;
    end
  end
  // program counter: reset vector, jump, held in the table cycle
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pc_r <= ADDR_W'(`PMT_RESET_VECTOR);
    end else if (!pc_hold) begin
      pc_r <= pc_nxt;
    end
  end
  // fetched word and its valid flag
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_instr <= 16'h0000;
      o_instr_valid <= 1'b0;
    end else begin
      o_instr_valid <= fetch_go;
      if (fetch_go) o_instr <= fetch_word;
    end
  end
  // table pointer and destination captured with the request
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tab_addr_r <= '0;
      dst_r <= 8'h00;
    end else if (tab_take) begin
      tab_addr_r <= tab_addr;
      dst_r <= i_tab_dst;
    end
  end
  // table results; the latch has no software write port
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_dm_wr <= 1'b0;
      o_dm_addr <= 8'h00;
      o_dm_data <= 8'h00;
      o_table_high_latch <= 8'h00;
    end else begin
      o_dm_wr <= st_table;
      if (st_table) begin
        o_dm_addr <= dst_r;
        o_dm_data <= tab_word[7:0];
        o_table_high_latch <= tab_word[15:8];
      end
    end
  end
  // registered program counter copy and busy flag
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pc <= '0;
      o_busy <= 1'b0;
    end else begin
      o_pc <= pc_r;
      o_busy <= (st_nxt != PMT_FETCH);
    end
  end
  // link clock: two-flop synchroniser plus edge history
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_s3_r <= 1'b0;
    end else begin
      ck_s1_r <= i_prog_serial_clock;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
    end
  end
  // link data: two-flop synchroniser
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      da_s1_r <= 1'b0;
      da_s2_r <= 1'b0;
    end else begin
      da_s1_r <= i_prog_serial_data;
      da_s2_r <= da_s1_r;
    end
  end
  // serial frame shifter, msb first, sampled on clock rise
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sh_r <= 32'h00000000;
    end else if (bit_take) begin
      sh_r <= frame;
    end
  end
  // bit counter, cleared while the pins are free
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r <= 6'h00;
    end else if (!pins_taken) begin
      cnt_r <= 6'h00;
    end else if (ck_rise) begin
      cnt_r <= frame_done ? 6'h00 : cnt_r + 6'h01;
    end
  end
  // programming writes into program memory, no reset on the array
  always_ff @(posedge i_mclk) begin
    if (frm_wr_pm) pmem[frm_addr] <= frame[15:0];
  end
  // eeprom strobe; address and data held until the next eeprom frame
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ee_wr <= 1'b0;
      o_ee_addr <= 8'h00;
      o_ee_data <= 8'h00;
    end else begin
      o_ee_wr <= frm_wr_ee;
      if (frm_wr_ee) begin
        o_ee_addr <= frm_ee_addr;
        o_ee_data <= frame[7:0];
      end
    end
  end
  // debug frame strobe and word, emulation variant only
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_dbg_valid <= 1'b0;
      o_dbg_word <= 32'h00000000;
    end else begin
      o_dbg_valid <= frm_dbg;
      if (frm_dbg) o_dbg_word <= frame;
    end
  end
  // read-back shifter: loaded at the half-way rise, shifted on each fall
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_sh_r <= 16'h0000;
    end else if (frm_rd) begin
      rd_sh_r <= pmem[rd_addr];
    end else if (rd_shift) begin
      rd_sh_r <= {rd_sh_r[14:0], 1'b0};
    end
  end
  // data pin drive: one bit per falling link clock edge
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_prog_serial_data <= 1'b0;
    end else if (rd_shift) begin
      o_prog_serial_data <= rd_sh_r[15];
    end
  end
  // data pin enable: on after the address half, off after the last bit
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_prog_serial_data_oe <= 1'b0;
    end else if (!pins_taken) begin
      o_prog_serial_data_oe <= 1'b0;
    end else if (frm_rd) begin
      o_prog_serial_data_oe <= 1'b1;
    end else if (rd_end) begin
      o_prog_serial_data_oe <= 1'b0;
    end
  end
  // pad drive per shared pin: general function cut off while the pins are taken
  for (genvar g = 0; g < 2; g++) begin : g_pad
    logic pad_r, pad_oe_r;
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        pad_r <= 1'b0;
        pad_oe_r <= 1'b0;
      end else begin
        pad_r <= pins_taken ? 1'b0 : gp_out[g];
        pad_oe_r <= pins_taken ? 1'b0 : gp_oe[g];
      end
    end
    assign pad_q[g] = pad_r;
    assign pad_oe_q[g] = pad_oe_r;
  end
  // pad outputs straight from the flops
  assign o_port_a_bit_zero_pad = pad_q[0];
  assign o_port_a_bit_zero_pad_oe = pad_oe_q[0];
  assign o_port_a_bit_two_pad = pad_q[1];
  assign o_port_a_bit_two_pad_oe = pad_oe_q[1];
endmodule : pmt_core
`default_nettype wire

// File: rtl/pmt_defs.svh
// constants for the program memory and table read block
`ifndef PMT_DEFS_SVH
`define PMT_DEFS_SVH
`define PMT_RESET_VECTOR 16'h0000
`define PMT_PAGE_WORDS 256
`define PMT_PAGE_BITS 8
`define PMT_WORD_BITS 16
`define PMT_FRAME_BITS 32
`define PMT_FRM_RD 31
`define PMT_FRM_EE 30
`define PMT_FRM_AD_HI 29
`define PMT_FRM_AD_LO 16
`endif

// File: rtl/pmt_pkg.sv
// types for the program memory and table read block
package pmt_pkg;
  typedef enum logic [1:0] {
    PMT_FETCH = 2'b00,
    PMT_TABLE = 2'b01,
    PMT_RESUME = 2'b10
  } pmt_state_type;
endpackage : pmt_pkg

// File: verification/pmt_checker.sv
// timing checks on the ports of the program memory block
`timescale 1ns/1ns
`default_nettype none
module pmt_checker #(
  parameter int ADDR_W = 11
) (
  // watched ports
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_tab_req,
  input wire logic i_prog_mode,
  input wire logic o_busy,
  input wire logic o_instr_valid,
  input wire logic o_dm_wr,
  input wire logic [ADDR_W-1:0] o_pc,
  input wire logic o_prog_serial_data_oe,
  input wire logic o_port_a_bit_zero_pad_oe,
  input wire logic o_ee_wr
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  // table read occupancy and result
  property p_tab_busy; i_tab_req && !o_busy |=> o_busy [*2] ##1 !o_busy; endproperty
  a_tab_busy: assert property (p_tab_busy) else $error("busy span wrong");
  property p_tab_gap; i_tab_req && !o_busy |=> ##1 !o_instr_valid ##1 o_instr_valid; endproperty
  a_tab_gap: assert property (p_tab_gap) else $error("fetch not held");
  property p_tab_wr; i_tab_req && !o_busy |-> ##2 o_dm_wr; endproperty
  a_tab_wr: assert property (p_tab_wr) else $error("no data write");
  property p_wr_cause; o_dm_wr |-> $past(o_busy) && o_busy; endproperty
  a_wr_cause: assert property (p_wr_cause) else $error("stray data write");
  // fetch starts at the reset vector
  property p_reset; $rose(i_rst_b) |=> o_pc == '0 && o_instr_valid; endproperty
  a_reset: assert property (p_reset) else $error("bad reset fetch");
  // programming pins
  property p_pad_off; i_prog_mode |=> !o_port_a_bit_zero_pad_oe; endproperty
  a_pad_off: assert property (p_pad_off) else $error("pad driven");
  property p_oe_mode; o_prog_serial_data_oe |-> $past(i_prog_mode); endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("data pin driven");
  property p_ee_wr; o_ee_wr |-> $past(i_prog_mode) ##1 !o_ee_wr; endproperty
  a_ee_wr: assert property (p_ee_wr) else $error("bad eeprom strobe");
endmodule : pmt_checker
bind pmt_core pmt_checker #(.ADDR_W(ADDR_W)) u_pmt_chk (.*);
`default_nettype wire

// File: verification/pmt_prog_model.sv
// serial programmer model: link clock and data, msb first
`timescale 1ns/1ns
`default_nettype none
module pmt_prog_model (
  // link pins toward the device
  output var logic o_ck,
  output var logic o_da,
  // pin level seen by the programmer, and the last 16 bits it sampled
  input wire logic i_da,
  output var logic [15:0] o_rd
);
  // idle pins
  initial begin
    o_ck = 1'h0;
    o_da = 1'h0;
    o_rd = 16'h0000;
  end
  // clock stands low between frames, data inverted once released
  task automatic send(input logic [31:0] f);
    for (int i = 31; i >= 0; i--) begin
      o_da = f[i];
      #62 o_ck = 1'h1;
      o_rd = {o_rd[14:0], i_da};
      #63 o_ck = 1'h0;
    end
    o_da = ~o_da;
  endtask : send
endmodule : pmt_prog_model
`default_nettype wire

// File: verification/tb_program_memory_table_read.sv
// testbench: loads words over the link, then table reads
`timescale 1ns/1ns
`default_nettype none
module tb_program_memory_table_read;
  localparam logic [15:0] HM = 16'h3fff;
  logic i_mclk, i_rst_b, i_jump, i_tab_req, i_tab_last, i_prog_mode, mdl_da;
  logic [10:0] i_jump_addr, o_pc;
  logic [7:0] i_tblp, i_tbhp, i_tab_dst, o_dm_addr, o_dm_data, o_table_high_latch;
  logic [7:0] o_ee_addr, o_ee_data;
  logic [15:0] o_instr, ee;
  logic [31:0] o_dbg_word, seed;
  logic o_instr_valid, o_dm_wr, o_busy, o_ee_wr, o_dbg_valid;
  logic i_prog_serial_clock, i_prog_serial_data, o_prog_serial_data, o_prog_serial_data_oe;
  logic i_port_a_bit_zero_out, i_port_a_bit_zero_oe;
  logic o_port_a_bit_zero_pad, o_port_a_bit_zero_pad_oe;
  logic i_port_a_bit_two_out, i_port_a_bit_two_oe;
  logic o_port_a_bit_two_pad, o_port_a_bit_two_pad_oe;
  logic [15:0] rd_word;
  logic [10:0] adr [6];
  logic [15:0] wrd [6];
  int num_errors = 0;
  int total_checks = 0;
  pmt_core #(.HIGH_MASK(HM)) DUT (.*);
  pmt_prog_model u_prog (
    .o_ck(i_prog_serial_clock),
    .o_da(mdl_da),
    .i_da(i_prog_serial_data),
    .o_rd(rd_word)
  );
  // pin level: device while it drives, else programmer
  assign i_prog_serial_data = o_prog_serial_data_oe ? o_prog_serial_data : mdl_da;
  // clock and watchdog
  initial begin
    i_mclk = 1'h0;
    forever #5 i_mclk = ~i_mclk;
  end
  initial begin
    #100000 num_errors++;
    wrap_up();
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [7:0] hi_exp(input logic [15:0] w);
    return w[15:8] & HM[15:8];
  endfunction : hi_exp
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // one table read, back to back with the previous
  task automatic tab(input logic [10:0] a, input logic last, input logic [15:0] w);
    int n;
    n = 1;
    while (o_busy !== 1'h0) @(posedge i_mclk) #1;
    i_tab_dst = 8'(xs());
    i_tbhp = last ? 8'(xs()) : {5'h00, a[10:8]};
    i_tblp = a[7:0];
    i_tab_last = last;
    i_tab_req = 1'h1;
    @(posedge i_mclk) #1 i_tab_req = 1'h0;
    while (o_dm_wr !== 1'h1 && n < 9) begin
      @(posedge i_mclk) #1 n++;
    end
    chk(n, 2);
    chk(o_dm_addr, i_tab_dst);
    chk(o_dm_data, w[7:0]);
    chk(o_table_high_latch, hi_exp(w));
  endtask : tab
  // main sequence
  initial begin
    seed = 32'h133b8;
    {i_rst_b, i_jump, i_tab_req, i_tab_last, i_jump_addr, i_tblp, i_tbhp, i_tab_dst} = '0;
    {i_prog_mode, i_port_a_bit_zero_out, i_port_a_bit_zero_oe} = 3'h7;
    {i_port_a_bit_two_out, i_port_a_bit_two_oe} = 2'h3;
    repeat (5) @(posedge i_mclk);
    #1 i_rst_b = 1'h1;
    @(posedge i_mclk) #1 chk(o_port_a_bit_zero_pad_oe, 0);
    chk(o_port_a_bit_two_pad_oe, 0);
    chk(o_port_a_bit_zero_pad, 0);
    for (int k = 0; k < 6; k++) begin
      adr[k] = {k == 5 ? 3'h7 : 3'(k), k == 0 ? 8'h00 : k == 4 ? 8'hff : 8'(xs())};
      wrd[k] = 16'(xs());
      u_prog.send({5'h00, adr[k], wrd[k]});
    end
    ee = 16'(xs());
    u_prog.send({2'h1, 6'h00, ee[15:8], 8'h00, ee[7:0]});
    u_prog.send({1'h1, 4'h0, adr[3], 16'h0000});
    #200 chk(o_ee_addr, ee[15:8]);
    chk(o_ee_data, ee[7:0]);
    chk(rd_word, wrd[3]);
    chk(o_prog_serial_data_oe, 0);
    @(posedge i_mclk) #1 i_prog_mode = 1'h0;
    @(posedge i_mclk) #1 chk(o_port_a_bit_zero_pad_oe, 1);
    chk(o_port_a_bit_two_pad_oe, 1);
    chk(o_port_a_bit_zero_pad, 1);
    chk(o_port_a_bit_two_pad, 1);
    i_rst_b = 1'h0;
    repeat (5) @(posedge i_mclk);
    #1 i_rst_b = 1'h1;
    @(posedge i_mclk) #1 chk(o_instr, wrd[0]);
    i_jump_addr = adr[2];
    i_jump = 1'h1;
    @(posedge i_mclk) #1 i_jump = 1'h0;
    @(posedge i_mclk) #1 chk(o_instr, wrd[2]);
    chk(o_pc, adr[2]);
    for (int k = 0; k < 6; k++) tab(adr[k], k == 5, wrd[k]);
    wrap_up();
  end
endmodule : tb_program_memory_table_read
`default_nettype wire
